/* File: verilog/adcc_regs.vh */
// Register map, field positions, reset values and counts for the converter control
`ifndef ADCC_REGS_VH
`define ADCC_REGS_VH
`define ADCC_OFF_STATUS_CONTROL 8'h38
`define ADCC_OFF_RESULT         8'h3C
`define ADCC_OFF_CLOCK          8'h40
`define ADCC_OFF_PORT_DATA      8'h44
`define ADCC_OFF_PORT_DIR       8'h48
`define ADCC_SC_DONE_BIT        7
`define ADCC_SC_IEN_BIT         6
`define ADCC_SC_CONT_BIT        5
`define ADCC_SC_CH_MSB          4
`define ADCC_CK_DIV_MSB         7
`define ADCC_CK_DIV_LSB         5
`define ADCC_CK_SRC_BIT         4
`define ADCC_CH_RESET           5'h1F
`define ADCC_CH_POWER_OFF       5'h1F
`define ADCC_SAMPLE_LAST        4'h7
`define ADCC_DECIDE_LAST        4'hF
`define ADCC_SAR_MSB_TRIAL      8'h80
`define ADCC_NUM_CH             15
`endif

/* File: verilog/adcc_sar.v */
// Successive approximation sequencer: sample, then eight bit decisions
`timescale 1ns/1ps
`include "adcc_regs.vh"
module adcc_sar (
    input  wire       i_clk,
    input  wire       i_sys_rst,
    input  wire       i_start,
    input  wire       i_abort,
    input  wire       i_tick,
    input  wire       i_cmp_above,
    output reg        o_busy,
    output wire       o_sampling,
    output reg        o_done,
    output reg  [7:0] o_result,
    output wire [7:0] o_trial
);
    reg       armed;
    reg [3:0] cnt;
    reg [7:0] sar;
    wire [7:0] mask = `ADCC_SAR_MSB_TRIAL >> cnt[2:0];
    // Keep the tried bit only if the input sits at or above the trial code
    wire [7:0] next_sar = (i_cmp_above ? sar : (sar & ~mask)) | (mask >> 1);

    assign o_trial    = sar;
    assign o_sampling = o_busy & ~armed & (cnt <= `ADCC_SAMPLE_LAST);

    always @(posedge i_clk) begin
        if (i_sys_rst) begin
            o_busy   <= 1'b0;
            o_done   <= 1'b0;
            o_result <= 8'h00;
            armed    <= 1'b0;
            cnt      <= 4'h0;
            sar      <= 8'h00;
        end else begin
            o_done <= 1'b0;
            if (i_abort) begin
                o_busy <= 1'b0;
            end else if (i_start) begin
                // A restart simply drops whatever was in progress
                o_busy <= 1'b1;
                armed  <= 1'b1;
                sar    <= 8'h00;
            end else if (o_busy && i_tick) begin
                if (armed) begin
                    // Aligning to the converter clock costs the 17th cycle
                    armed <= 1'b0;
                    cnt   <= 4'h0;
                end else begin
                    cnt <= cnt + 4'h1;
                    if (cnt == `ADCC_SAMPLE_LAST) begin
                        sar <= `ADCC_SAR_MSB_TRIAL;
                    end else if (cnt > `ADCC_SAMPLE_LAST) begin
                        sar <= next_sar;
                    end
                    if (cnt == `ADCC_DECIDE_LAST) begin
                        o_result <= next_sar;
                        o_done   <= 1'b1;
                        o_busy   <= 1'b0;
                    end
                end
            end
        end
    end
endmodule

/* File: verilog/adcc_port.v */
// Shared port pins with converter override of the selected pin
`timescale 1ns/1ps
module adcc_port #(
    parameter N = 15
) (
    input  wire         i_clk,
    input  wire         i_sys_rst,
    input  wire         i_wr_data,
    input  wire         i_wr_dir,
    input  wire [N-1:0] i_wdata,
    input  wire [N-1:0] i_sel,
    input  wire [N-1:0] i_pin_in,
    output reg  [N-1:0] o_pin_out,
    output wire [N-1:0] o_pin_oe,
    output wire [N-1:0] o_port_read,
    output reg  [N-1:0] o_dir
);
    always @(posedge i_clk) begin
        if (i_sys_rst) begin
            o_pin_out <= {N{1'b0}};
            o_dir     <= {N{1'b0}};
        end else begin
            // Bits of the converter pin keep their old value on a write
            if (i_wr_data) begin
                o_pin_out <= (o_pin_out & i_sel) | (i_wdata & ~i_sel);
            end
            if (i_wr_dir) begin
                o_dir <= (o_dir & i_sel) | (i_wdata & ~i_sel);
            end
        end
    end

    genvar g;
    generate
        for (g = 0; g < N; g = g + 1) begin : pin
            // Never drive a pin the converter is sampling
            assign o_pin_oe[g]    = o_dir[g] & ~i_sel[g];
            assign o_port_read[g] = o_dir[g] ? o_pin_out[g] :
                                    (i_sel[g] ? 1'b0 : i_pin_in[g]);
        end
    endgenerate
endmodule

/* File: verilog/adcc_top.v */
// Converter control: AHB-Lite registers, clock prescaler, sequencing, pin override
`timescale 1ns/1ps
`include "adcc_regs.vh"
// Functional notes
// - Route one of fifteen channels by select field
// - Eight-bit result by successive approximation
// - Store result, then flag or interrupt
// - Selected pin forced to converter input
// - Converter pin reads 0 unless direction set
// - High reference gives all ones, ground zeros
// - Status write starts; 16 to 17 clocks
// - Continuous mode overwrites result each conversion
// - Continuous conversions until software clears bit
// - Continuous flag stays until write or read
// - Interrupt enabled: request per conversion, flag unused
// - Runs in wait; interrupt can wake
// - Stop aborts conversion; resumes after stop
// - With interrupts, flag is read/write; reset clears
// - All-ones select powers off; reset value
// - Unused channel codes give undefined results
// - Prescaler divides by 1, 2, 4, 8, 16
module adcc_top #(
    parameter NCH = `ADCC_NUM_CH
) (
    input  wire            i_clk,
    input  wire            i_sys_rst,
    input  wire            i_hsel,
    input  wire [7:0]      i_haddr,
    input  wire [1:0]      i_htrans,
    input  wire            i_hwrite,
    input  wire [2:0]      i_hsize,
    input  wire [31:0]     i_hwdata,
    input  wire            i_hready,
    output wire            o_hreadyout,
    output wire            o_hresp,
    output reg  [31:0]     o_hrdata,
    input  wire            i_osc_tick,
    input  wire            i_stop_mode,
    input  wire            i_wait_mode,
    input  wire            i_cmp_above,
    input  wire [NCH-1:0]  i_pin_in,
    output wire [NCH-1:0]  o_pin_out,
    output wire [NCH-1:0]  o_pin_oe,
    output wire [4:0]      o_mux_sel,
    output wire            o_adc_power_on,
    output wire            o_sampling,
    output wire [7:0]      o_trial_code,
    output wire            o_conv_irq
);
    reg         done_flag;
    reg         ien;
    reg         cont;
    reg  [4:0]  ch;
    reg  [2:0]  div;
    reg         src_bus;
    reg  [3:0]  div_cnt;
    reg  [3:0]  div_tc;
    reg         irq_req;
    reg         stop_d;
    reg         resume;
    reg         ap_wr;
    reg  [7:0]  ap_addr;
    reg         rd_wait;
    reg  [7:0]  rd_byte;

    wire        busy;
    wire        conv_done;
    wire [7:0]  result;
    wire [NCH-1:0] port_read;
    wire [NCH-1:0] dir;
    wire [NCH-1:0] sel_onehot;

    // AHB-Lite: writes have no wait state, reads one so side effects settle
    wire accept  = i_hsel & i_htrans[1] & i_hready;
    assign o_hreadyout = ~rd_wait;
    assign o_hresp     = 1'b0;

    wire wr_sc   = ap_wr && (ap_addr == `ADCC_OFF_STATUS_CONTROL);
    wire wr_clk  = ap_wr && (ap_addr == `ADCC_OFF_CLOCK);
    wire wr_pd   = ap_wr && (ap_addr == `ADCC_OFF_PORT_DATA);
    wire wr_dir  = ap_wr && (ap_addr == `ADCC_OFF_PORT_DIR);
    wire rd_res  = rd_wait && (ap_addr == `ADCC_OFF_RESULT);

    wire [4:0] new_ch   = i_hwdata[`ADCC_SC_CH_MSB:0];
    wire       powered  = (ch != `ADCC_CH_POWER_OFF);
    wire       new_pwr  = (new_ch != `ADCC_CH_POWER_OFF);

    // Select field picks one shared pin; codes above fourteen pick none
    genvar g;
    generate
        for (g = 0; g < NCH; g = g + 1) begin : chsel
            localparam [4:0] ch_code = g;
            assign sel_onehot[g] = powered && (ch == ch_code);
        end
    endgenerate

    assign o_mux_sel      = ch;
    assign o_adc_power_on = powered & ~i_stop_mode;

    // Prescaler on the chosen source; changing it mid-conversion corrupts the result
    wire src_tick = src_bus | i_osc_tick;
    // At or above the terminal count, so a smaller divider acts on the next source tick
    wire adc_tick = src_tick && (div_cnt >= div_tc);

    always @* begin
        case (div)
            3'b000:  div_tc = 4'h0;
            3'b001:  div_tc = 4'h1;
            3'b010:  div_tc = 4'h3;
            3'b011:  div_tc = 4'h7;
            default: div_tc = 4'hF;
        endcase
    end

    always @(posedge i_clk) begin
        if (i_sys_rst) begin
            div_cnt <= 4'h0;
        end else if (src_tick) begin
            div_cnt <= adc_tick ? 4'h0 : div_cnt + 4'h1;
        end
    end

    // Start sources: status write, continuous refill, return from stop
    wire stop_exit  = stop_d & ~i_stop_mode;
    wire sw_start   = wr_sc & new_pwr;
    wire cont_start = conv_done & cont & powered & ~wr_sc;
    wire res_start  = stop_exit & resume & powered;
    wire start      = ~i_stop_mode & (sw_start | cont_start | res_start);
    // Power-off also halts the sequencer; unused codes still convert (undefined)
    wire abort      = i_stop_mode | (wr_sc & ~new_pwr);

    adcc_sar u_sar (
        .i_clk       (i_clk),
        .i_sys_rst   (i_sys_rst),
        .i_start     (start),
        .i_abort     (abort),
        .i_tick      (adc_tick),
        .i_cmp_above (i_cmp_above),
        .o_busy      (busy),
        .o_sampling  (o_sampling),
        .o_done      (conv_done),
        .o_result    (result),
        .o_trial     (o_trial_code)
    );

    adcc_port #(
        .N (NCH)
    ) u_port (
        .i_clk       (i_clk),
        .i_sys_rst   (i_sys_rst),
        .i_wr_data   (wr_pd),
        .i_wr_dir    (wr_dir),
        .i_wdata     (i_hwdata[NCH-1:0]),
        .i_sel       (sel_onehot),
        .i_pin_in    (i_pin_in),
        .o_pin_out   (o_pin_out),
        .o_pin_oe    (o_pin_oe),
        .o_port_read (port_read),
        .o_dir       (dir)
    );

    // Stop bookkeeping: remember an aborted or continuous run to resume it
    always @(posedge i_clk) begin
        if (i_sys_rst) begin
            stop_d <= 1'b0;
            resume <= 1'b0;
        end else begin
            stop_d <= i_stop_mode;
            if (i_stop_mode && !stop_d) begin
                resume <= busy | cont;
            end else if (stop_exit) begin
                resume <= 1'b0;
            end
        end
    end

    // Status, control and clock registers
    always @(posedge i_clk) begin
        if (i_sys_rst) begin
            done_flag <= 1'b0;
            ien       <= 1'b0;
            cont      <= 1'b0;
            ch        <= `ADCC_CH_RESET;
            div       <= 3'b000;
            src_bus   <= 1'b0;
            irq_req   <= 1'b0;
        end else begin
            if (wr_sc) begin
                ien  <= i_hwdata[`ADCC_SC_IEN_BIT];
                cont <= i_hwdata[`ADCC_SC_CONT_BIT];
                ch   <= new_ch;
            end
            if (wr_clk) begin
                div     <= i_hwdata[`ADCC_CK_DIV_MSB:`ADCC_CK_DIV_LSB];
                src_bus <= i_hwdata[`ADCC_CK_SRC_BIT];
            end
            // Flag: completion sets it (set beats clear) unless interrupts own it
            if (conv_done && !ien) begin
                done_flag <= 1'b1;
            end else if (wr_sc) begin
                done_flag <= ien ? i_hwdata[`ADCC_SC_DONE_BIT] : 1'b0;
            end else if (rd_res && !ien) begin
                done_flag <= 1'b0;
            end
            // Request after each conversion; it also runs in wait mode to wake the core
            if (conv_done && ien) begin
                irq_req <= 1'b1;
            end else if (wr_sc || rd_res) begin
                irq_req <= 1'b0;
            end
        end
    end

    assign o_conv_irq = irq_req & ien;

    // Bus address phase capture and read data
    always @* begin
        case (ap_addr)
            `ADCC_OFF_STATUS_CONTROL: rd_byte = {done_flag, ien, cont, ch};
            `ADCC_OFF_RESULT:         rd_byte = result;
            `ADCC_OFF_CLOCK:          rd_byte = {div, src_bus, 4'h0};
            default:                  rd_byte = 8'h00;
        endcase
    end

    always @(posedge i_clk) begin
        if (i_sys_rst) begin
            ap_wr    <= 1'b0;
            ap_addr  <= 8'h00;
            rd_wait  <= 1'b0;
            o_hrdata <= 32'h0000_0000;
        end else begin
            ap_wr   <= accept & i_hwrite;
            rd_wait <= accept & ~i_hwrite;
            if (accept) begin
                ap_addr <= i_haddr;
            end
            if (rd_wait) begin
                if (ap_addr == `ADCC_OFF_PORT_DATA) begin
                    o_hrdata <= {{(32-NCH){1'b0}}, port_read};
                end else if (ap_addr == `ADCC_OFF_PORT_DIR) begin
                    o_hrdata <= {{(32-NCH){1'b0}}, dir};
                end else begin
                    o_hrdata <= {24'h000000, rd_byte};
                end
            end
        end
    end

    // Wait mode needs no gating here; software owns the power-down choice
    wire unused_ok = i_wait_mode | (|i_hsize) | i_htrans[0];
endmodule

/* File: verilog/adcc_dummy_guard.v */
// No logic here; the converter control is complete without this file

/* File: verification/adcc_checker.sv */
// Port checker for the converter control, bound to its top module
`timescale 1ns/1ps
`include "adcc_regs.vh"
module adcc_checker #(
    parameter NCH = 15
) (
    input wire            i_clk,
    input wire            i_sys_rst,
    input wire            i_hsel,
    input wire [7:0]      i_haddr,
    input wire [1:0]      i_htrans,
    input wire            i_hwrite,
    input wire            i_hready,
    input wire            i_stop_mode,
    input wire            o_hreadyout,
    input wire            o_hresp,
    input wire [31:0]     o_hrdata,
    input wire [NCH-1:0]  o_pin_oe,
    input wire [4:0]      o_mux_sel,
    input wire            o_adc_power_on,
    input wire            o_sampling,
    input wire            o_conv_irq
);
    reg  wr_sc;
    wire take = i_hsel && i_htrans[1] && i_hready;
    // A status write is the only legal cause of a channel change
    always @(posedge i_clk) begin
        wr_sc <= !i_sys_rst && take && i_hwrite && (i_haddr == `ADCC_OFF_STATUS_CONTROL);
    end
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);
    sequence s_rd; take && !i_hwrite; endsequence
    sequence s_ws; !o_hreadyout ##1 o_hreadyout; endsequence
    property p_rd_wait; s_rd |=> s_ws; endproperty
    a_rd_wait: assert property (p_rd_wait) else $error("read wait state wrong");
    property p_resp; o_hresp == 1'b0; endproperty
    a_resp: assert property (p_resp) else $error("response not okay");
    property p_hold; o_hreadyout && $past(o_hreadyout) |-> $stable(o_hrdata); endproperty
    a_hold: assert property (p_hold) else $error("read data moved");
    property p_sel; $changed(o_mux_sel) |-> $past(wr_sc); endproperty
    a_sel: assert property (p_sel) else $error("channel changed alone");
    property p_oe; o_mux_sel < 5'h0F |-> !o_pin_oe[o_mux_sel[3:0]]; endproperty
    a_oe: assert property (p_oe) else $error("selected pin driven");
    property p_off; o_mux_sel == 5'h1F |-> !o_adc_power_on; endproperty
    a_off: assert property (p_off) else $error("powered with all ones");
    property p_stop; i_stop_mode && $past(i_stop_mode) |-> !o_adc_power_on && !o_sampling;
    endproperty
    a_stop: assert property (p_stop) else $error("active in stop");
    property p_rst; disable iff (1'b0) i_sys_rst |=> o_mux_sel == 5'h1F && !o_conv_irq;
    endproperty
    a_rst: assert property (p_rst) else $error("bad reset state");
endmodule
bind adcc_top adcc_checker #(.NCH(NCH)) u_chk (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
    .i_hsel(i_hsel), .i_haddr(i_haddr), .i_htrans(i_htrans), .i_hwrite(i_hwrite),
    .i_hready(i_hready), .i_stop_mode(i_stop_mode), .o_hreadyout(o_hreadyout),
    .o_hresp(o_hresp), .o_hrdata(o_hrdata), .o_pin_oe(o_pin_oe), .o_mux_sel(o_mux_sel),
    .o_adc_power_on(o_adc_power_on), .o_sampling(o_sampling), .o_conv_irq(o_conv_irq));

/* File: verification/adcc_pins_model.sv */
// Far side model: analog sources, comparator and external pin drivers
`timescale 1ns/1ps
module adcc_pins_model (
    input  wire [14:0]      i_pin_out,
    input  wire [14:0]      i_pin_oe,
    input  wire [4:0]       i_mux_sel,
    input  wire [7:0]       i_trial_code,
    input  wire [14:0][7:0] i_level,
    input  wire [14:0]      i_ext,
    output wire [14:0]      o_pin_in,
    output wire             o_cmp_above
);
    // Internal reference codes give full scale and ground
    wire [7:0] lvl = (i_mux_sel < 5'h0F) ? i_level[i_mux_sel[3:0]] :
                     (i_mux_sel == 5'h1D) ? 8'hFF : 8'h00;
    assign o_cmp_above = (lvl >= i_trial_code);
    // Pins not driven by the port see the outside driver
    assign o_pin_in = (i_pin_oe & i_pin_out) | (~i_pin_oe & i_ext);
endmodule

/* File: verification/tb.sv */
// Self-checking bench of the converter control
`timescale 1ns/1ps
module tb;
    reg              i_clk, i_sys_rst, i_osc_tick, i_stop_mode, i_wait_mode, i_hwrite;
    reg  [7:0]       i_haddr;
    reg  [1:0]       i_htrans;
    reg  [31:0]      i_hwdata, rd;
    reg  [14:0][7:0] lvl;
    reg  [1:0]       oc;
    integer          mismatches, samples_checked, k;
    wire             o_hreadyout, o_hresp, o_adc_power_on, o_sampling, o_conv_irq, cmp;
    wire [31:0]      o_hrdata;
    wire [14:0]      o_pin_out, o_pin_oe, pin_in;
    wire [4:0]       o_mux_sel;
    wire [7:0]       o_trial_code;
    reg  [7:0]       t_ck [0:6];
    reg  [4:0]       t_ch [0:6];
    integer          t_d  [0:6];
    adcc_top dut (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_hsel(1'b1), .i_haddr(i_haddr),
        .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hsize(3'h2), .i_hwdata(i_hwdata),
        .i_hready(o_hreadyout), .o_hreadyout(o_hreadyout), .o_hresp(o_hresp),
        .o_hrdata(o_hrdata), .i_osc_tick(i_osc_tick), .i_stop_mode(i_stop_mode),
        .i_wait_mode(i_wait_mode), .i_cmp_above(cmp), .i_pin_in(pin_in),
        .o_pin_out(o_pin_out), .o_pin_oe(o_pin_oe), .o_mux_sel(o_mux_sel),
        .o_adc_power_on(o_adc_power_on), .o_sampling(o_sampling),
        .o_trial_code(o_trial_code), .o_conv_irq(o_conv_irq));
    adcc_pins_model u_far (.i_pin_out(o_pin_out), .i_pin_oe(o_pin_oe), .i_mux_sel(o_mux_sel),
        .i_trial_code(o_trial_code), .i_level(lvl), .i_ext(15'h2AAA), .o_pin_in(pin_in),
        .o_cmp_above(cmp));
    function [7:0] lv(input [4:0] c);
        lv = (c < 5'h0F) ? (8'hA5 ^ (8'h11 * c)) : ((c == 5'h1D) ? 8'hFF : 8'h00);
    endfunction
    task chk(input [31:0] seen, input [31:0] exp);
        begin
            samples_checked = samples_checked + 1;
            if (seen !== exp) begin
                mismatches = mismatches + 1;
                $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
            end
        end
    endtask
    // Ready is looked at on the falling edge, so the rising edge sees the same value
    task hold;
        begin
            @(negedge i_clk);
            while (o_hreadyout !== 1'b1) @(negedge i_clk);
            rd = o_hrdata;
            @(posedge i_clk);
        end
    endtask
    task bus(input w, input [7:0] a, input [31:0] d);
        begin
            i_htrans <= 2'h2;
            i_haddr  <= a;
            i_hwrite <= w;
            hold;
            i_htrans <= 2'h0;
            i_hwdata <= d;
            hold;
        end
    endtask
    task wr(input [7:0] a, input [31:0] d);
        bus(1'b1, a, d);
    endtask
    task rdm(input [7:0] a, input [31:0] m, input [31:0] e);
        begin
            bus(1'b0, a, 32'h0);
            chk(rd & m, e);
        end
    endtask
    task final_report;
        begin
            $display("compared %0d, mismatches %0d", samples_checked, mismatches);
            if (mismatches == 0 && samples_checked > 0)
                $display("All checks passed");
            else
                $display("Checks failed");
            $finish;
        end
    endtask
    initial begin
        i_clk = 0;
        forever #50 i_clk = ~i_clk;
    end
    always @(posedge i_clk) begin
        if (i_sys_rst) begin
            oc         <= 2'h0;
            i_osc_tick <= 1'b0;
        end else begin
            oc         <= oc + 2'h1;
            i_osc_tick <= (oc == 2'h3);
        end
    end
    initial begin
        #1000000;
        mismatches = mismatches + 1;
        final_report;
    end
    initial begin
        {i_sys_rst, i_stop_mode, i_wait_mode, i_hwrite} = 4'h8;
        {i_haddr, i_htrans, i_hwdata, mismatches, samples_checked} = 0;
        for (k = 0; k < 15; k = k + 1) lvl[k] = lv(k);
        t_ck = '{8'h10, 8'h30, 8'h50, 8'h70, 8'h90, 8'hF0, 8'h20};
        t_d  = '{1, 2, 4, 8, 16, 16, 8};
        t_ch = '{5'h00, 5'h05, 5'h09, 5'h0D, 5'h1D, 5'h1E, 5'h0E};
        repeat (3) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        // Port data reads the outside level on the low eight pins while nothing is selected
        for (k = 0; k < 6; k = k + 1)
            rdm(8'h38 + 4 * k, 32'hFF, (k == 0) ? 32'h1F : ((k == 3) ? 32'hAA : 0));
        wr(8'h48, 32'h7FFF);
        for (k = 0; k < 7; k = k + 1) begin
            // Each prescaler divisor and an oscillator row, timed from the status write
            wr(8'h40, t_ck[k]);
            wr(8'h38, t_ch[k]);
            repeat (16 * t_d[k] - 1) @(posedge i_clk);
            rdm(8'h38, 32'h80, 32'h0);
            chk(o_mux_sel, t_ch[k]);
            chk(o_pin_oe, 15'h7FFF & ~(15'h1 << t_ch[k]));
            repeat (t_d[k]) @(posedge i_clk);
            rdm(8'h38, 32'h80, 32'h80);
            rdm(8'h3C, 32'hFF, lv(t_ch[k]));
        end
        $display("end of prescaler table");
        wr(8'h38, 32'h1F);
        wr(8'h48, 32'h0);
        wr(8'h44, 32'h7FFF);
        wr(8'h38, 32'h05);
        rdm(8'h44, 32'h7FFF, 32'h2A8A);
        wr(8'h48, 32'h7FFF);
        wr(8'h44, 32'h0);
        wr(8'h38, 32'h1F);
        chk(o_pin_out, 15'h0020);
        chk(o_pin_oe, 15'h7FDF);
        $display("end of pin override");
        wr(8'h40, 32'h10);
        wr(8'h38, 32'h22);
        repeat (25) @(posedge i_clk);
        lvl[2] <= 8'h99;
        repeat (40) @(posedge i_clk);
        rdm(8'h38, 32'h80, 32'h80);
        rdm(8'h3C, 32'hFF, 32'h99);
        repeat (25) @(posedge i_clk);
        rdm(8'h38, 32'h80, 32'h80);
        wr(8'h38, 32'h1F);
        @(posedge i_clk);
        chk(o_adc_power_on, 1'b0);
        $display("end of continuous mode");
        i_wait_mode <= 1'b1;
        wr(8'h38, 32'h43);
        repeat (25) @(posedge i_clk);
        chk(o_conv_irq, 1'b1);
        rdm(8'h38, 32'h80, 32'h0);
        rdm(8'h3C, 32'hFF, lv(3));
        chk(o_conv_irq, 1'b0);
        wr(8'h38, 32'hC3);
        rdm(8'h38, 32'h80, 32'h80);
        wr(8'h38, 32'h1F);
        i_wait_mode <= 1'b0;
        $display("end of interrupt and wait");
        wr(8'h38, 32'h07);
        repeat (5) @(posedge i_clk);
        i_stop_mode <= 1'b1;
        repeat (2) @(posedge i_clk);
        chk(o_adc_power_on, 1'b0);
        repeat (30) @(posedge i_clk);
        rdm(8'h38, 32'h80, 32'h0);
        i_stop_mode <= 1'b0;
        repeat (40) @(posedge i_clk);
        rdm(8'h38, 32'h80, 32'h80);
        rdm(8'h3C, 32'hFF, lv(7));
        $display("end of stop mode");
        wr(8'h38, 32'h09);
        repeat (6) @(posedge i_clk);
        wr(8'h38, 32'h0D);
        repeat (25) @(posedge i_clk);
        rdm(8'h3C, 32'hFF, lv(13));
        $display("end of restart");
        wr(8'h38, 32'h45);
        repeat (25) @(posedge i_clk);
        chk(o_conv_irq, 1'b1);
        i_sys_rst <= 1'b1;
        repeat (3) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        chk(o_conv_irq, 1'b0);
        chk(o_mux_sel, 5'h1F);
        chk({o_hreadyout, o_adc_power_on, o_pin_out}, {2'b10, 15'h0000});
        rdm(8'h38, 32'hFF, 32'h1F);
        $display("end of mid-run reset");
        final_report;
    end
endmodule
